/* hdl/usart_spi_cfg.svh */
// constants of the master spi serial engine
// What this block does
// [RULE_01] frame, overrun and parity flags are unused and always read zero
// [RULE_02] rx complete (status bit 7) is set while unread receive data exists
// [RULE_03] clearing receiver enable flushes the receive buffer
// [RULE_04] tx complete (status bit 6) sets when frame done and buffer empty
// [RULE_05] tx complete clears on interrupt taken or on writing a one
// [RULE_06] buffer empty (status bit 5) is one when buffer accepts a byte
// [RULE_07] software writes zeros to status bits 4 to 0
// [RULE_08] rx interrupt needs enable bit 7, global flag and rx complete
// [RULE_09] tx interrupt needs enable bit 6, global flag and tx complete
// [RULE_10] empty interrupt needs enable bit 5, global flag and buffer empty
// [RULE_11] receiver enable (bit 4) takes over the serial input pin
// [RULE_12] software does not enable the receiver without the transmitter
// [RULE_13] transmitter disable waits until shift register and buffer empty
// [RULE_14] mode field bits 7:6: 00 async, 01 sync, 10 reserved, 11 spi
// [RULE_15] order, phase and polarity take effect in the mode-select write
// [RULE_16] order bit 2: one shifts lsb first, zero msb first
// [RULE_17] phase bit 1 picks leading or trailing edge for sampling
// [RULE_18] polarity bit 0 sets the idle level of the shift clock
// [RULE_19] transmit holding buffer plus one extra receive buffer level
// [RULE_20] master only, no select input, no collision flag
// [RULE_21] software writes zeros to reserved control and mode bits
// [RULE_22] a data register write starts every transfer
// [RULE_23] on receive overflow the newest byte is dropped
// [RULE_24] data changes and is sampled on opposite shift clock edges
// [RULE_25] shift clock period is two times divisor plus one system clocks
`ifndef USART_SPI_CFG_SVH
`define USART_SPI_CFG_SVH

// ************************************************
// register byte addresses
// ************************************************
`define ADDR_DATA     8'h00
`define ADDR_STATUS   8'h04
`define ADDR_CONTROL  8'h08
`define ADDR_MODE     8'h0C
`define ADDR_BAUD     8'h10

// ************************************************
// field positions
// ************************************************
`define BIT_RXC       7
`define BIT_TXC       6
`define BIT_UDRE      5
`define BIT_RXCIE     7
`define BIT_TXCIE     6
`define BIT_EMPTYIE   5
`define BIT_RXEN      4
`define BIT_TXEN      3
`define BIT_ORDER     2
`define BIT_CPHA      1
`define BIT_CPOL      0

// ************************************************
// reset values and counts
// ************************************************
`define CONTROL_RST   8'h06
`define MODE_RST      8'h00
`define BAUD_RST      12'h000
`define LAST_EDGE     4'hf
`define RX_DEPTH      2'h2

`endif

/* hdl/usart_spi_pkg.sv */
// types of the master spi serial engine
package usart_spi_pkg;

    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_SYNC,
        MODE_RSVD,
        MODE_MSPI
    } mode_t;

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } engine_t;

    // control fields written by software
    typedef struct packed {
        logic rxcie;
        logic txcie;
        logic emptyie;
        logic rxen;
        logic txen;
    } ctrl_t;

    // frame format fields
    typedef struct packed {
        logic [1:0] msel;
        logic       order;
        logic       cpha;
        logic       cpol;
    } fmt_t;

endpackage

/* hdl/usart_spi.sv */
// master spi engine built on a serial port, with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "usart_spi_cfg.svh"

module usart_spi
    import usart_spi_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        global_irq_enable_in,
    input  wire logic        tx_irq_ack_in,
    input  wire logic        serial_in_pin_in,
    output logic             serial_out_pin_out,
    output logic             shift_clock_pin_out,
    output logic             tx_override_out,
    output logic             rx_override_out,
    output logic             rx_irq_out,
    output logic             tx_irq_out,
    output logic             empty_irq_out
);

    // ************************************************
    // declarations
    // ************************************************
    ctrl_t       ctrl_q;
    fmt_t        fmt_q;
    mode_t       mode;
    engine_t     st_q;
    logic [11:0] baud_q;
    logic [11:0] cnt_q;
    logic [3:0]  edge_q;
    logic        sck_q;
    logic        mosi_q;
    logic [7:0]  tx_sh_q;
    logic [7:0]  rx_sh_q;
    logic [7:0]  txbuf_q;
    logic        txfull_q;
    logic        txon_q;
    logic        txc_q;
    logic [7:0]  rxbuf_q [2];
    logic [1:0]  rxcnt_q;
    logic        miso_m_q;
    logic        miso_q;
    logic        ap_wr_q;
    logic        ap_rd_q;
    logic        rd_ok_q;
    logic [7:0]  ap_addr_q;
    logic [31:0] hrdata_q;
    logic [7:0]  rd_mux;
    logic        accept;
    logic        wr_data;
    logic        wr_stat;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        wr_baud;
    logic        rd_pop;
    logic        tick;
    logic        start;
    logic        done;
    logic        sample;
    logic        setup;
    logic        rx_push;
    logic        spi_on;
    logic        out_bit;
    logic        in_bit;
    logic [7:0]  rx_byte;

    // ************************************************
    // ahb-lite slave
    // ************************************************

    // address phase taken when selected with an active transfer and the bus is ready
    assign accept = hsel_in & htrans_in[1] & hready_in;

    // writes finish with no wait, reads take one wait state
    assign hreadyout_out = ~ap_rd_q | rd_ok_q;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;

    // address phase capture
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ap_wr_q   <= 1'b0;
            ap_rd_q   <= 1'b0;
            ap_addr_q <= 8'h00;
        end else if (hready_in) begin
            ap_wr_q   <= accept & hwrite_in;
            ap_rd_q   <= accept & ~hwrite_in;
            ap_addr_q <= haddr_in;
        end
    end

    // read data registered in the wait cycle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_ok_q  <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else if (ap_rd_q & ~rd_ok_q) begin
            rd_ok_q  <= 1'b1;
            hrdata_q <= {24'h00_0000, rd_mux};
        end else if (hready_in) begin
            rd_ok_q  <= 1'b0;
        end
    end

    // write strobes in the data phase
    assign wr_data = ap_wr_q & (ap_addr_q == `ADDR_DATA);
    assign wr_stat = ap_wr_q & (ap_addr_q == `ADDR_STATUS);
    assign wr_ctrl = ap_wr_q & (ap_addr_q == `ADDR_CONTROL);
    assign wr_mode = ap_wr_q & (ap_addr_q == `ADDR_MODE);
    assign wr_baud = ap_wr_q & (ap_addr_q == `ADDR_BAUD);
    assign rd_pop  = ap_rd_q & ~rd_ok_q & (ap_addr_q == `ADDR_DATA);

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (ap_addr_q)
            `ADDR_DATA: begin
                rd_mux = rxbuf_q[0];
            end
            `ADDR_STATUS: begin
                // error flags stay zero in this mode
                rd_mux[`BIT_RXC]  = (rxcnt_q != 2'h0); // [RULE_02] [RULE_01]
                rd_mux[`BIT_TXC]  = txc_q;
                rd_mux[`BIT_UDRE] = ~txfull_q; // [RULE_06]
            end
            `ADDR_CONTROL: begin
                rd_mux = {ctrl_q, 3'b110};
            end
            `ADDR_MODE: begin
                rd_mux = {fmt_q.msel, 3'b000, fmt_q.order,
                          fmt_q.cpha, fmt_q.cpol};
            end
            `ADDR_BAUD: begin
                rd_mux = baud_q[7:0];
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // ************************************************
    // configuration registers
    // ************************************************

    // control enables; reserved low bits are not stored
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= ctrl_t'(`CONTROL_RST >> 3);
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_t'(hwdata_in[7:3]); // [RULE_21]
        end
    end

    // mode and frame format change together in one write
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fmt_q <= fmt_t'({2'(`MODE_RST >> 6), 3'(`MODE_RST)});
        end else if (wr_mode) begin
            fmt_q.msel  <= hwdata_in[7:6]; // [RULE_15]
            fmt_q.order <= hwdata_in[`BIT_ORDER];
            fmt_q.cpha  <= hwdata_in[`BIT_CPHA];
            fmt_q.cpol  <= hwdata_in[`BIT_CPOL];
        end
    end

    // divisor: low byte at the baud word, high nibble in bits 11:8
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            baud_q <= `BAUD_RST;
        end else if (wr_baud) begin
            baud_q <= hwdata_in[11:0];
        end
    end

    // decode of the mode field
    always_comb begin
        unique case (fmt_q.msel) // [RULE_14]
            2'b00: mode = MODE_ASYNC;
            2'b01: mode = MODE_SYNC;
            2'b10: mode = MODE_RSVD;
            2'b11: mode = MODE_MSPI;
        endcase
    end

    // only the spi master mode is built; other modes leave pins alone
    assign spi_on = (mode == MODE_MSPI);

    // ************************************************
    // transmitter enable and holding buffer
    // ************************************************

    // disable waits for the shift register and buffer to drain
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            txon_q <= 1'b0;
        end else if (ctrl_q.txen) begin
            txon_q <= 1'b1;
        end else if (st_q == ST_IDLE && !txfull_q) begin
            txon_q <= 1'b0; // [RULE_13]
        end
    end

    // a data write fills the buffer while the transmitter is on; full buffer ignores writes
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            txfull_q <= 1'b0;
            txbuf_q  <= 8'h00;
        end else if (wr_data && !txfull_q && txon_q) begin
            txfull_q <= 1'b1; // [RULE_22] [RULE_19]
            txbuf_q  <= hwdata_in[7:0];
        end else if (start) begin
            txfull_q <= 1'b0;
        end
    end

    // completion flag: set wins over either clear
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            txc_q <= 1'b0;
        end else if (done && !txfull_q) begin
            txc_q <= 1'b1; // [RULE_04]
        end else if (tx_irq_ack_in) begin
            txc_q <= 1'b0; // [RULE_05]
        end else if (wr_stat && hwdata_in[`BIT_TXC]) begin
            txc_q <= 1'b0; // [RULE_05] [RULE_07]
        end
    end

    // ************************************************
    // baud generator
    // ************************************************

    // one tick every divisor plus one cycles gives half a clock period
    assign tick = (st_q == ST_SHIFT) && (cnt_q == 12'h000);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 12'h000;
        end else if (start || tick) begin
            cnt_q <= baud_q; // [RULE_25]
        end else if (st_q == ST_SHIFT) begin
            cnt_q <= cnt_q - 12'h001;
        end
    end

    // ************************************************
    // shift engine
    // ************************************************

    // no select input exists; a full buffer starts a frame when the transmitter is on in spi mode
    assign start = (st_q == ST_IDLE) && txfull_q && txon_q && spi_on; // [RULE_20]
    assign done  = tick && (edge_q == `LAST_EDGE);

    // even edges lead, odd trail; phase picks the sampling one
    assign sample = tick && (edge_q[0] == fmt_q.cpha); // [RULE_17]
    assign setup  = tick && (edge_q[0] != fmt_q.cpha); // [RULE_24]

    // next outgoing bit follows the data order
    assign out_bit = fmt_q.order ? tx_sh_q[0] : tx_sh_q[7]; // [RULE_16]

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= ST_IDLE;
        end else if (start) begin
            st_q <= ST_SHIFT;
        end else if (done) begin
            st_q <= ST_IDLE;
        end
    end

    // edge counter and clock level
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            edge_q <= 4'h0;
            sck_q  <= 1'b0;
        end else if (start) begin
            edge_q <= 4'h0;
            sck_q  <= 1'b0;
        end else if (tick) begin
            edge_q <= edge_q + 4'h1;
            sck_q  <= ~sck_q;
        end
    end

    // phase zero puts the first bit out before the first edge
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_sh_q <= 8'h00;
            mosi_q  <= 1'b1;
        end else if (start) begin
            if (fmt_q.cpha) begin
                tx_sh_q <= txbuf_q;
            end else begin
                mosi_q  <= fmt_q.order ? txbuf_q[0] : txbuf_q[7];
                tx_sh_q <= fmt_q.order ? {1'b0, txbuf_q[7:1]}
                                       : {txbuf_q[6:0], 1'b0};
            end
        end else if (setup) begin
            mosi_q  <= out_bit; // [RULE_24]
            tx_sh_q <= fmt_q.order ? {1'b0, tx_sh_q[7:1]}
                                   : {tx_sh_q[6:0], 1'b0};
        end
    end

    // input pin crosses into the core clock before use
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            miso_m_q <= 1'b0;
            miso_q   <= 1'b0;
        end else begin
            miso_m_q <= serial_in_pin_in;
            miso_q   <= miso_m_q;
        end
    end

    // the receiver owns the input only while enabled
    assign in_bit = ctrl_q.rxen & miso_q; // [RULE_11]

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_sh_q <= 8'h00;
        end else if (sample) begin
            rx_sh_q <= rx_byte; // [RULE_16]
        end
    end

    // ************************************************
    // receive buffer, two levels
    // ************************************************

    // incoming bit merged per data order; with phase one the last sample
    // falls on the done edge itself, so the pushed byte must include it
    assign rx_byte = !sample ? rx_sh_q
                   : fmt_q.order ? {in_bit, rx_sh_q[7:1]} : {rx_sh_q[6:0], in_bit};
    assign rx_push = done && ctrl_q.rxen;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rxcnt_q    <= 2'h0;
            rxbuf_q[0] <= 8'h00;
            rxbuf_q[1] <= 8'h00;
        end else if (!ctrl_q.rxen) begin
            rxcnt_q <= 2'h0; // [RULE_03]
        end else begin
            if (rd_pop && rxcnt_q != 2'h0) begin
                rxbuf_q[0] <= rxbuf_q[1];
            end
            // a full buffer drops the newest byte
            if (rx_push && (rxcnt_q != `RX_DEPTH || rd_pop)) begin // [RULE_23]
                if (rxcnt_q == 2'h0 || (rxcnt_q == 2'h1 && rd_pop)) begin
                    rxbuf_q[0] <= rx_byte;
                end else begin
                    rxbuf_q[1] <= rx_byte;
                end
            end
            // occupancy: push only counts when it was accepted
            if (rd_pop && rxcnt_q != 2'h0) begin
                if (!(rx_push)) begin
                    rxcnt_q <= rxcnt_q - 2'h1;
                end
            end else if (rx_push && rxcnt_q != `RX_DEPTH) begin
                rxcnt_q <= rxcnt_q + 2'h1; // [RULE_19] [RULE_02]
            end
        end
    end

    // ************************************************
    // pins and interrupt requests
    // ************************************************

    // polarity flips the idle level and every edge
    assign shift_clock_pin_out = sck_q ^ fmt_q.cpol; // [RULE_18]
    assign serial_out_pin_out  = mosi_q;
    assign tx_override_out     = txon_q & spi_on; // [RULE_13]
    assign rx_override_out     = ctrl_q.rxen & spi_on; // [RULE_11]

    // each request needs its enable and the global flag
    assign rx_irq_out    = ctrl_q.rxcie & global_irq_enable_in
                         & (rxcnt_q != 2'h0); // [RULE_08]
    assign tx_irq_out    = ctrl_q.txcie & global_irq_enable_in
                         & txc_q; // [RULE_09]
    assign empty_irq_out = ctrl_q.emptyie & global_irq_enable_in
                         & ~txfull_q; // [RULE_10]

endmodule
`default_nettype wire

/* bench/usart_spi_chk.sv */
// concurrent checks on the ports of the master spi engine
`timescale 1ns/1ps
`default_nettype none
`include "usart_spi_cfg.svh"

module usart_spi_chk (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_out,
    input  wire logic        hreadyout_out,
    input  wire logic        hresp_out,
    input  wire logic        global_irq_enable_in,
    input  wire logic        serial_out_pin_out,
    input  wire logic        tx_override_out,
    input  wire logic        rx_irq_out,
    input  wire logic        tx_irq_out,
    input  wire logic        empty_irq_out
);
    logic       take;
    logic       rd_q;
    logic [7:0] addr_q;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    // address phase taken
    assign take = hsel_in && htrans_in[1] && hready_in;

    // register of the pending read
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end else if (take) begin
            rd_q   <= !hwrite_in;
            addr_q <= haddr_in;
        end else if (hreadyout_out) begin
            rd_q <= 1'b0;
        end
    end

    // ****************************************
    // bus timing and flag checks
    // ****************************************
    a_read_wait: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite_in |=> hreadyout_out)
        else $error("write stretched");
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("slave response was not okay");
    a_err_bits_zero: assert property (rd_q && hreadyout_out && addr_q == `ADDR_STATUS |-> hrdata_out[4:0] == 5'h00)
        else $error("unused status bits read nonzero");
    a_rx_irq_gate: assert property (rx_irq_out |-> global_irq_enable_in)
        else $error("rx irq without global flag");
    a_tx_irq_gate: assert property (tx_irq_out |-> global_irq_enable_in)
        else $error("tx irq without global flag");
    a_empty_irq_gate: assert property (empty_irq_out |-> global_irq_enable_in)
        else $error("empty irq without global flag");
    a_idle_line_still: assert property (!tx_override_out && !$past(tx_override_out) |-> $stable(serial_out_pin_out))
        else $error("released data line moved");
endmodule
`default_nettype wire

/* bench/spi_slave_model.sv */
// behavioural spi slave answering the master engine
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       cpol_in,
    input  wire logic       cpha_in,
    input  wire logic       lsb_in,
    input  wire logic       arm_in,
    input  wire logic [7:0] base_in,
    output logic            miso_out,
    output logic      [7:0] rx_out
);
    int         n = 0;
    logic [7:0] k = 8'h00;
    logic [7:0] sh = 8'h00;

    // reply byte grows by one per frame so a lost byte shows
    function automatic logic pick(input int i);
        logic [7:0] b;
        b = base_in + k;
        return lsb_in ? b[i] : b[7 - i];
    endfunction

    // ****************************************
    // frame handling
    // ****************************************
    initial begin
        miso_out = 1'b0;
        rx_out = 8'h00;
    end

    // arming restarts the count and puts the first bit out early
    always @(posedge arm_in) begin
        n = 0;
        k = 8'h00;
        miso_out = pick(0);
    end

    // leading edge leaves the idle level; phase picks the sampling edge
    always @(sck_in) begin
        if (arm_in) begin
            if ((sck_in != cpol_in) != cpha_in) begin
                sh = lsb_in ? {mosi_in, sh[7:1]} : {sh[6:0], mosi_in};
                n = n + 1;
                if (n == 8) begin
                    rx_out = sh;
                    n = 0;
                    k = k + 8'h01;
                end
            end else begin
                miso_out = pick(n);
            end
        end
    end
endmodule
`default_nettype wire

/* bench/usart_master_spi_mode_bench.sv */
// self-checking bench of the master spi engine with a slave model
`timescale 1ns/1ps
`default_nettype none
`include "usart_spi_cfg.svh"

module usart_master_spi_mode_bench;
    typedef struct packed {
        logic [2:0] fmt;
        logic [7:0] tx;
        logic [7:0] sl;
    } row_t;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        glob = 1'b0;
    logic        ack = 1'b0;
    logic        arm = 1'b0;
    logic [2:0]  fmt = 3'b000;
    logic [7:0]  base = 8'h00;
    int          fail_count = 0;
    int          tests_run = 0;
    wire  [31:0] hrdata;
    wire  [7:0]  srx;
    wire         hready, hresp, miso, mosi, sck, txo, rxo, rxi, txi, emi;
    // one row per clock mode, both bit orders among them
    row_t rows [4] = '{'{3'b000, 8'hA5, 8'h3C}, '{3'b011, 8'h81, 8'h5E},
                       '{3'b101, 8'hC3, 8'h96}, '{3'b110, 8'h2D, 8'hE1}};

    always #12.5 clk = ~clk;

    usart_spi i_dut (.core_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .global_irq_enable_in(glob), .tx_irq_ack_in(ack), .serial_in_pin_in(miso),
        .serial_out_pin_out(mosi), .shift_clock_pin_out(sck), .tx_override_out(txo),
        .rx_override_out(rxo), .rx_irq_out(rxi), .tx_irq_out(txi), .empty_irq_out(emi));

    spi_slave_model i_slave (.sck_in(sck), .mosi_in(mosi), .cpol_in(fmt[0]), .cpha_in(fmt[1]),
        .lsb_in(fmt[2]), .arm_in(arm), .base_in(base), .miso_out(miso), .rx_out(srx));

    // ****************************************
    // bus and checking tasks
    // ****************************************
    // single transfer; each phase holds until an edge samples hready high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, a, 8'h00, d);
        chk(d, e);
    endtask

    // polls the status until the frame is out; clearing is optional
    task automatic wait_txc(input logic clr);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 80 && s[6] !== 1'b1; i++) begin
            bus(1'b0, `ADDR_STATUS, 8'h00, s);
        end
        chk({7'h00, s[6]}, 8'h01);
        if (clr) begin
            wr(`ADDR_STATUS, 8'h40);
        end
    endtask

    task automatic close_out();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        #1_000_000;
        fail_count++;
        close_out();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rdc(`ADDR_CONTROL, 8'h06);
        rdc(`ADDR_STATUS, 8'h20);
        rdc(`ADDR_MODE, 8'h00);
        wr(`ADDR_CONTROL, 8'h18);
        wr(`ADDR_BAUD, 8'h02);
        foreach (rows[i]) begin
            arm  <= 1'b0;
            fmt  <= rows[i].fmt;
            base <= rows[i].sl;
            wr(`ADDR_MODE, {5'b11000, rows[i].fmt});
            @(negedge clk);
            chk({6'h00, rxo, sck}, {7'h01, rows[i].fmt[0]});
            arm <= 1'b1;
            wr(`ADDR_DATA, rows[i].tx);
            wait_txc(1'b1);
            chk(srx, rows[i].tx);
            rdc(`ADDR_DATA, rows[i].sl);
            rdc(`ADDR_STATUS, 8'h20);
        end
        // interrupt gating by enable, global flag and acknowledge
        glob <= 1'b1;
        wr(`ADDR_CONTROL, 8'h38);
        @(negedge clk);
        chk({7'h00, emi}, 8'h01);
        @(posedge clk);
        glob <= 1'b0;
        @(negedge clk);
        chk({7'h00, emi}, 8'h00);
        @(posedge clk);
        glob <= 1'b1;
        wr(`ADDR_CONTROL, 8'hD8);
        wr(`ADDR_DATA, 8'h5A);
        wait_txc(1'b0);
        @(negedge clk);
        chk({6'h00, rxi, txi}, 8'h03);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(negedge clk);
        chk({7'h00, txi}, 8'h00);
        rdc(`ADDR_STATUS, 8'hA0);
        wr(`ADDR_CONTROL, 8'h08);
        rdc(`ADDR_STATUS, 8'h20);
        // three frames unread: the newest is dropped, older kept
        wr(`ADDR_CONTROL, 8'h18);
        arm <= 1'b0;
        @(posedge clk);
        arm <= 1'b1;
        wr(`ADDR_DATA, 8'h11);
        wr(`ADDR_DATA, 8'h22);
        rdc(`ADDR_STATUS, 8'h00);
        wait_txc(1'b1);
        wr(`ADDR_DATA, 8'h33);
        wait_txc(1'b1);
        chk(srx, 8'h33);
        rdc(`ADDR_DATA, rows[3].sl);
        rdc(`ADDR_DATA, rows[3].sl + 8'h01);
        rdc(`ADDR_STATUS, 8'h20);
        // transmitter disable waits for buffered data
        wr(`ADDR_DATA, 8'h44);
        wr(`ADDR_DATA, 8'h55);
        wr(`ADDR_CONTROL, 8'h00);
        @(negedge clk);
        chk({7'h00, txo}, 8'h01);
        wait_txc(1'b1);
        chk(srx, 8'h55);
        chk({7'h00, txo}, 8'h00);
        // a mode other than master spi never shifts
        wr(`ADDR_MODE, 8'h40);
        wr(`ADDR_CONTROL, 8'h18);
        wr(`ADDR_DATA, 8'h66);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk({6'h00, rxo, txo}, 8'h00);
        chk(srx, 8'h55);
        rdc(`ADDR_MODE, 8'h40);
        rdc(8'h14, 8'h00);
        close_out();
    end
endmodule

bind usart_spi usart_spi_chk i_chk (.core_clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .global_irq_enable_in,
    .serial_out_pin_out, .tx_override_out, .rx_irq_out, .tx_irq_out, .empty_irq_out);
`default_nettype wire
